//--- hw/caes_addr_gen.v
`timescale 1ns/1ps
`include "caes_defines.vh"

module caes_addr_gen (
    // operand context
    input  wire [3:0]  i_mode,
    input  wire [15:0] i_pc,
    input  wire [15:0] i_hx,
    input  wire [15:0] i_sp,
    input  wire [15:0] i_off,
    input  wire        i_br_cond,
    // formed address or operand value
    output reg  [15:0] o_ea
);

    wire [15:0] off8_z;
    wire [15:0] off8_s;
    wire [15:0] pc_next;

    // 16-bit sums drop the carry, so every address wraps
    assign off8_z  = {8'h00, i_off[7:0]};
    assign off8_s  = {{8{i_off[7]}}, i_off[7:0]};
    assign pc_next = i_pc + `CAES_INC;

    // address forming per mode
    always @* begin
        case (i_mode)
            `CAES_BRANCH_OFFSET_MODE:
                o_ea = i_br_cond ? pc_next + off8_s : pc_next;
            `CAES_INLINE8_MODE:  o_ea = off8_z;
            `CAES_INLINE16_MODE: o_ea = i_off;
            `CAES_PAGE_ZERO_MODE:
                o_ea = {`CAES_PAGE_ZERO_HI, i_off[7:0]};
            `CAES_FULL_ADDRESS_MODE: o_ea = i_off;
            `CAES_INDEX_PLAIN_MODE,
            `CAES_INDEX_POSTINC_MODE: o_ea = i_hx;
            `CAES_INDEX_OFF8_MODE,
            `CAES_INDEX_OFF8_POSTINC_MODE:
                o_ea = i_hx + off8_z;
            `CAES_INDEX_OFF16_MODE: o_ea = i_hx + i_off;
            `CAES_STACK_OFF8_MODE:  o_ea = i_sp + off8_z;
            `CAES_STACK_OFF16_MODE: o_ea = i_sp + i_off;
            default: o_ea = 16'h0000;
        endcase
    end

endmodule

//--- hw/caes_defines.vh
`ifndef CAES_DEFINES_VH
`define CAES_DEFINES_VH

// operand addressing modes, 4-bit codes
`define CAES_REGISTER_ONLY_MODE      4'h0
`define CAES_BRANCH_OFFSET_MODE      4'h1
`define CAES_INLINE8_MODE            4'h2
`define CAES_INLINE16_MODE           4'h3
`define CAES_PAGE_ZERO_MODE          4'h4
`define CAES_FULL_ADDRESS_MODE       4'h5
`define CAES_INDEX_PLAIN_MODE        4'h6
`define CAES_INDEX_POSTINC_MODE      4'h7
`define CAES_INDEX_OFF8_MODE         4'h8
`define CAES_INDEX_OFF8_POSTINC_MODE 4'h9
`define CAES_INDEX_OFF16_MODE        4'hA
`define CAES_STACK_OFF8_MODE         4'hB
`define CAES_STACK_OFF16_MODE        4'hC

// vectors and fixed values
`define CAES_RESET_VEC    16'hFFFE
`define CAES_TRAP_VEC     16'hFFFC
`define CAES_IRQ_VEC_TOP  16'hFFFA
`define CAES_PAGE_ZERO_HI 8'h00
`define CAES_INC          16'h0001
`define CAES_MASK_BIT     3
`define CAES_FILL_LAST    2'h2
`define CAES_PUSH_LAST    3'h4

`endif

//--- hw/caes_seq.v
`timescale 1ns/1ps
`include "caes_defines.vh"

module caes_seq #(
    parameter NIRQ = 8
) (
    // clock and reset
    input  wire            i_sys_clk,
    input  wire            i_rstn,
    // reset completion
    input  wire            i_ext_rst_n,
    input  wire            i_src_done,
    // cpu core state and events
    input  wire            i_boundary,
    input  wire            i_trap_op,
    input  wire            i_wait_op,
    input  wire            i_mask_clr,
    input  wire [15:0]     i_pc,
    input  wire [15:0]     i_hx,
    input  wire [15:0]     i_sp,
    input  wire [7:0]      i_acc,
    input  wire [7:0]      i_ccr,
    // operand request
    input  wire            i_ea_req,
    input  wire [3:0]      i_ea_mode,
    input  wire            i_br_cond,
    // interrupt sources and debug
    input  wire [NIRQ-1:0] i_irq_pend,
    input  wire            i_dbg_halt,
    input  wire            i_dbg_go,
    // memory bus
    input  wire [7:0]      i_bus_rdata,
    output wire [15:0]     o_bus_addr,
    output wire            o_bus_rd,
    output wire            o_bus_wr,
    output wire [7:0]      o_bus_wdata,
    output wire            o_qfill,
    // results to the core
    output wire            o_busy,
    output wire            o_ea_done,
    output wire [15:0]     o_ea,
    output wire [7:0]      o_opnd,
    output wire            o_hx_wr,
    output wire [15:0]     o_hx_new,
    output wire            o_sp_wr,
    output wire [15:0]     o_sp_new,
    output wire            o_pc_wr,
    output wire [15:0]     o_pc_new,
    output wire            o_set_mask,
    output wire            o_clr_mask,
    output wire            o_cpu_clk_en,
    output wire            o_bgnd
);

    ////////////////////////////////////////////////////////////////////
    // states, one-hot
    localparam [10:0] S_RSTW  = 11'h001;
    localparam [10:0] S_VHI   = 11'h002;
    localparam [10:0] S_VLO   = 11'h004;
    localparam [10:0] S_FREE  = 11'h008;
    localparam [10:0] S_FILL  = 11'h010;
    localparam [10:0] S_IDLE  = 11'h020;
    localparam [10:0] S_OFF   = 11'h040;
    localparam [10:0] S_OPND  = 11'h080;
    localparam [10:0] S_PUSH  = 11'h100;
    localparam [10:0] S_SLEEP = 11'h200;
    localparam [10:0] S_BGND  = 11'h400;

    reg [10:0] state_q;
    reg        rst_pin_m_q;
    reg        rst_pin_s_q;
    reg [15:0] addr_q;
    reg        rd_q;
    reg        wr_q;
    reg [7:0]  wdata_q;
    reg        qfill_q;
    reg [2:0]  cnt_q;
    reg [1:0]  nb_q;
    reg [3:0]  mode_q;
    reg        brc_q;
    reg [15:0] pc_q;
    reg [15:0] hx_q;
    reg [15:0] sp_q;
    reg [15:0] off_q;
    reg [15:0] vec_q;
    reg [15:0] tgt_q;
    reg [39:0] stk_q;
    reg        done_q;
    reg [15:0] ea_q;
    reg [7:0]  opnd_q;
    reg        hx_wr_q;
    reg [15:0] hx_new_q;
    reg        sp_wr_q;
    reg        pc_wr_q;
    reg        set_mask_q;
    reg        clr_mask_q;
    reg        clk_en_q;
    reg        bgnd_q;

    reg [1:0]  nb_req;
    reg        mem_req;
    reg        irq_any;
    reg [15:0] irq_vec;
    integer    k;

    wire [15:0] off_now;
    wire [15:0] gen_ea;
    wire        mem_mode;
    wire        post_inc;
    wire        irq_ok;

    ////////////////////////////////////////////////////////////////////
    // reset pin synchroniser; the first stage feeds only the second
    always @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_pin_m_q <= 1'b0;
            rst_pin_s_q <= 1'b0;
        end else begin
            rst_pin_m_q <= i_ext_rst_n;
            rst_pin_s_q <= rst_pin_m_q;
        end
    end

    // offset bytes needed per mode, and whether the operand is read
    always @* begin
        nb_req  = 2'd0;
        mem_req = 1'b1;
        case (i_ea_mode)
            `CAES_REGISTER_ONLY_MODE: mem_req = 1'b0;
            `CAES_BRANCH_OFFSET_MODE, `CAES_INLINE8_MODE: begin
                nb_req  = 2'd1;
                mem_req = 1'b0;
            end
            `CAES_INLINE16_MODE: begin
                nb_req  = 2'd2;
                mem_req = 1'b0;
            end
            `CAES_PAGE_ZERO_MODE, `CAES_INDEX_OFF8_MODE,
            `CAES_INDEX_OFF8_POSTINC_MODE, `CAES_STACK_OFF8_MODE:
                nb_req = 2'd1;
            `CAES_FULL_ADDRESS_MODE, `CAES_INDEX_OFF16_MODE,
            `CAES_STACK_OFF16_MODE:
                nb_req = 2'd2;
            default: nb_req = 2'd0;
        endcase
    end

    // lowest index wins: scanning downward lets it overwrite
    always @* begin
        irq_any = 1'b0;
        irq_vec = `CAES_IRQ_VEC_TOP;
        for (k = NIRQ - 1; k >= 0; k = k - 1) begin
            if (i_irq_pend[k]) begin
                irq_any = 1'b1;
                irq_vec = `CAES_IRQ_VEC_TOP - {k[14:0], 1'b0};
            end
        end
    end

    // an instruction clearing the mask blocks interrupt entry at this boundary
    assign irq_ok = irq_any & ~i_ccr[`CAES_MASK_BIT] & ~i_mask_clr;

    // the last offset byte joins the earlier one, upper byte first
    assign off_now  = (nb_q == 2'd2) ? {off_q[7:0], i_bus_rdata}
                                     : {8'h00, i_bus_rdata};
    assign mem_mode = (mode_q != `CAES_BRANCH_OFFSET_MODE) &&
                      (mode_q != `CAES_INLINE8_MODE) &&
                      (mode_q != `CAES_INLINE16_MODE);
    assign post_inc = (mode_q == `CAES_INDEX_POSTINC_MODE) ||
                      (mode_q == `CAES_INDEX_OFF8_POSTINC_MODE);

    caes_addr_gen u_gen (
        .i_mode    (mode_q),
        .i_pc      (pc_q),
        .i_hx      (hx_q),
        .i_sp      (sp_q),
        .i_off     (off_now),
        .i_br_cond (brc_q),
        .o_ea      (gen_ea)
    );

    ////////////////////////////////////////////////////////////////////
    // main sequencer; async reset drops any activity at once
    always @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_q    <= S_RSTW;
            addr_q     <= 16'h0000;
            rd_q       <= 1'b0;
            wr_q       <= 1'b0;
            wdata_q    <= 8'h00;
            qfill_q    <= 1'b0;
            cnt_q      <= 3'h0;
            nb_q       <= 2'h0;
            mode_q     <= 4'h0;
            brc_q      <= 1'b0;
            pc_q       <= 16'h0000;
            hx_q       <= 16'h0000;
            sp_q       <= 16'h0000;
            off_q      <= 16'h0000;
            vec_q      <= 16'h0000;
            tgt_q      <= 16'h0000;
            stk_q      <= 40'h00_0000_0000;
            done_q     <= 1'b0;
            ea_q       <= 16'h0000;
            opnd_q     <= 8'h00;
            hx_wr_q    <= 1'b0;
            hx_new_q   <= 16'h0000;
            sp_wr_q    <= 1'b0;
            pc_wr_q    <= 1'b0;
            set_mask_q <= 1'b0;
            clr_mask_q <= 1'b0;
            clk_en_q   <= 1'b0;
            bgnd_q     <= 1'b0;
        end else begin
            // one-cycle strobes fall back unless set below
            done_q     <= 1'b0;
            hx_wr_q    <= 1'b0;
            sp_wr_q    <= 1'b0;
            pc_wr_q    <= 1'b0;
            set_mask_q <= 1'b0;
            clr_mask_q <= 1'b0;
            case (state_q)
                S_RSTW: begin
                    // both the source check and the pin must be done
                    if (rst_pin_s_q && i_src_done) begin
                        vec_q  <= `CAES_RESET_VEC;
                        addr_q <= `CAES_RESET_VEC;
                        rd_q   <= 1'b1;
                        state_q <= S_VHI;
                    end
                end
                S_VHI: begin
                    tgt_q[15:8] <= i_bus_rdata;
                    addr_q      <= vec_q + `CAES_INC;
                    state_q     <= S_VLO;
                end
                S_VLO: begin
                    tgt_q[7:0] <= i_bus_rdata;
                    rd_q       <= 1'b0;
                    state_q    <= S_FREE;
                end
                S_FREE: begin
                    // free bus cycle, then queue refill
                    addr_q  <= tgt_q;
                    rd_q    <= 1'b1;
                    qfill_q <= 1'b1;
                    cnt_q   <= 3'h0;
                    state_q <= S_FILL;
                end
                S_FILL: begin
                    addr_q <= addr_q + `CAES_INC;
                    cnt_q  <= cnt_q + 3'h1;
                    if (cnt_q[1:0] == `CAES_FILL_LAST) begin
                        rd_q     <= 1'b0;
                        qfill_q  <= 1'b0;
                        pc_wr_q  <= 1'b1;
                        clk_en_q <= 1'b1;
                        state_q  <= S_IDLE;
                    end
                end
                S_IDLE: begin
                    if (i_boundary && (i_trap_op || irq_ok)) begin
                        // taken only at a boundary: i_pc is next
                        // trap ignores the mask
                        vec_q   <= i_trap_op ? `CAES_TRAP_VEC
                                             : irq_vec;
                        // upper index byte left out of the frame
                        stk_q   <= {i_ccr, i_acc, i_hx[7:0],
                                    i_pc[15:8], 8'h00};
                        wdata_q <= i_pc[7:0];
                        addr_q  <= i_sp;
                        wr_q    <= 1'b1;
                        cnt_q   <= 3'h0;
                        state_q <= S_PUSH;
                    end else if (i_wait_op) begin
                        clr_mask_q <= 1'b1;
                        clk_en_q   <= 1'b0;
                        state_q    <= S_SLEEP;
                    end else if (i_ea_req) begin
                        mode_q <= i_ea_mode;
                        brc_q  <= i_br_cond;
                        pc_q   <= i_pc;
                        hx_q   <= i_hx;
                        sp_q   <= i_sp;
                        nb_q   <= nb_req;
                        cnt_q  <= 3'h0;
                        if (nb_req != 2'd0) begin
                            addr_q  <= i_pc;
                            rd_q    <= 1'b1;
                            state_q <= S_OFF;
                        end else if (mem_req) begin
                            // plain index: operand sits at the pair
                            ea_q    <= i_hx;
                            addr_q  <= i_hx;
                            rd_q    <= 1'b1;
                            state_q <= S_OPND;
                        end else begin
                            ea_q   <= 16'h0000;
                            done_q <= 1'b1;
                        end
                    end
                end
                S_OFF: begin
                    off_q  <= off_now;
                    cnt_q  <= cnt_q + 3'h1;
                    addr_q <= addr_q + `CAES_INC;
                    if (cnt_q[1:0] + 2'd1 == nb_q) begin
                        ea_q <= gen_ea;
                        if (mem_mode) begin
                            addr_q  <= gen_ea;
                            state_q <= S_OPND;
                        end else begin
                            rd_q    <= 1'b0;
                            done_q  <= 1'b1;
                            state_q <= S_IDLE;
                        end
                    end
                end
                S_OPND: begin
                    // pair is bumped only after the fetch
                    opnd_q  <= i_bus_rdata;
                    rd_q    <= 1'b0;
                    done_q  <= 1'b1;
                    hx_wr_q <= post_inc;
                    hx_new_q <= hx_q + `CAES_INC;
                    state_q <= S_IDLE;
                end
                S_PUSH: begin
                    addr_q  <= addr_q - `CAES_INC;
                    cnt_q   <= cnt_q + 3'h1;
                    wdata_q <= stk_q[15:8];
                    stk_q   <= {8'h00, stk_q[39:8]};
                    if (cnt_q == `CAES_PUSH_LAST) begin
                        wr_q       <= 1'b0;
                        set_mask_q <= 1'b1;
                        sp_q       <= addr_q - `CAES_INC;
                        sp_wr_q    <= 1'b1;
                        addr_q     <= vec_q;
                        rd_q       <= 1'b1;
                        state_q    <= S_VHI;
                    end
                end
                S_SLEEP: begin
                    // the sequencer itself keeps running to watch wakes
                    if (i_dbg_halt) begin
                        clk_en_q <= 1'b1;
                        bgnd_q   <= 1'b1;
                        state_q  <= S_BGND;
                    end else if (irq_any) begin
                        // pc already points past the wait; enter direct
                        clk_en_q <= 1'b1;
                        vec_q    <= irq_vec;
                        stk_q    <= {i_ccr, i_acc, i_hx[7:0],
                                     i_pc[15:8], 8'h00};
                        wdata_q  <= i_pc[7:0];
                        addr_q   <= i_sp;
                        wr_q     <= 1'b1;
                        cnt_q    <= 3'h0;
                        state_q  <= S_PUSH;
                    end
                end
                S_BGND: begin
                    if (i_dbg_go) begin
                        bgnd_q  <= 1'b0;
                        state_q <= S_IDLE;
                    end
                end
                default: state_q <= S_RSTW;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs
    assign o_bus_addr   = addr_q;
    assign o_bus_rd     = rd_q;
    assign o_bus_wr     = wr_q;
    assign o_bus_wdata  = wdata_q;
    assign o_qfill      = qfill_q;
    assign o_busy       = (state_q != S_IDLE);
    assign o_ea_done    = done_q;
    assign o_ea         = ea_q;
    assign o_opnd       = opnd_q;
    assign o_hx_wr      = hx_wr_q;
    assign o_hx_new     = hx_new_q;
    assign o_sp_wr      = sp_wr_q;
    assign o_sp_new     = sp_q;
    assign o_pc_wr      = pc_wr_q;
    assign o_pc_new     = tgt_q;
    assign o_set_mask   = set_mask_q;
    assign o_clr_mask   = clr_mask_q;
    assign o_cpu_clk_en = clk_en_q;
    assign o_bgnd       = bgnd_q;

endmodule

//--- verification/caes_mem_model.sv
`timescale 1ns/1ps
module caes_mem_model (
    // clock
    input  wire        i_sys_clk,
    // bus from the sequencer
    input  wire [15:0] i_addr,
    input  wire        i_rd,
    input  wire        i_wr,
    input  wire [7:0]  i_wdata,
    // read data back
    output wire [7:0]  o_rdata
);
    reg     [7:0] mem_q [0:65535];
    reg     [7:0] last_q;
    integer       k;
    // pattern: a wrong address in the same page reads wrong data
    initial begin
        last_q = 8'h00;
        for (k = 0; k < 65536; k = k + 1)
            mem_q[k] = k[7:0] ^ k[15:8] ^ 8'hA5;
    end
    // no wait states; an idle bus never repeats the last byte
    assign o_rdata = i_rd ? mem_q[i_addr] : ~last_q;
    // writes land at the edge ending the write cycle
    always @(posedge i_sys_clk) begin
        if (i_wr)
            mem_q[i_addr] <= i_wdata;
        if (i_rd)
            last_q <= o_rdata;
    end
endmodule

//--- verification/caes_seq_asserts.sv
`timescale 1ns/1ps
`include "caes_defines.vh"
module caes_seq_asserts (
    // clock and reset
    input wire        i_sys_clk,
    input wire        i_rstn,
    // core events and registers
    input wire        i_boundary,
    input wire        i_trap_op,
    input wire        i_wait_op,
    input wire [15:0] i_pc,
    input wire [15:0] i_hx,
    input wire [15:0] i_sp,
    input wire [7:0]  i_acc,
    input wire [7:0]  i_ccr,
    input wire        i_ea_req,
    input wire [3:0]  i_ea_mode,
    // memory bus
    input wire [7:0]  i_bus_rdata,
    input wire [15:0] o_bus_addr,
    input wire        o_bus_rd,
    input wire        o_bus_wr,
    input wire [7:0]  o_bus_wdata,
    input wire        o_qfill,
    // results
    input wire        o_busy,
    input wire        o_ea_done,
    input wire        o_hx_wr,
    input wire [15:0] o_hx_new,
    input wire        o_sp_wr,
    input wire        o_pc_wr,
    input wire        o_set_mask,
    input wire        o_clr_mask,
    input wire        o_cpu_clk_en
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);
    // requests lose to entry and wait
    wire req_ok = i_ea_req && !o_busy && !i_boundary && !i_wait_op;
    ////////////////////////////////////////////////////////////////////////
    property p_reg_only;
        req_ok && i_ea_mode == `CAES_REGISTER_ONLY_MODE |=> o_ea_done && !o_bus_rd;
    endproperty
    a_reg_only: assert property (p_reg_only) else $error("reg-only read");
    property p_full;
        req_ok && i_ea_mode == `CAES_FULL_ADDRESS_MODE |=> o_bus_rd &&
        o_bus_addr == $past(i_pc) ##1 o_bus_addr == $past(i_pc, 2) + 16'h0001
        ##1 o_bus_rd && o_bus_addr == {$past(i_bus_rdata, 2), $past(i_bus_rdata)}
        ##1 o_ea_done;
    endproperty
    a_full: assert property (p_full) else $error("full address wrong");
    property p_postinc;
        req_ok && i_ea_mode == `CAES_INDEX_POSTINC_MODE |=> o_bus_rd &&
        o_bus_addr == $past(i_hx) ##1 o_ea_done && o_hx_wr &&
        o_hx_new == $past(i_hx, 2) + 16'h0001;
    endproperty
    a_postinc: assert property (p_postinc) else $error("postinc wrong");
    property p_rst_vec;
        o_bus_rd && !o_cpu_clk_en && o_bus_addr == 16'hFFFE |=> o_bus_rd &&
        o_bus_addr == 16'hFFFF ##1 !o_bus_rd ##1 o_bus_rd && o_bus_addr ==
        {$past(i_bus_rdata, 3), $past(i_bus_rdata, 2)} ##1 o_bus_rd[*2]
        ##1 o_pc_wr;
    endproperty
    a_rst_vec: assert property (p_rst_vec) else $error("reset fetch");
    property p_push;
        $rose(o_bus_wr) |-> o_bus_addr == i_sp && o_bus_wdata == i_pc[7:0]
        ##1 o_bus_wdata == i_pc[15:8] && o_bus_addr == $past(o_bus_addr) - 16'h0001
        ##1 o_bus_wdata == i_hx[7:0] ##1 o_bus_wdata == i_acc
        ##1 o_bus_wr && o_bus_wdata == i_ccr ##1 !o_bus_wr;
    endproperty
    a_push: assert property (p_push) else $error("stacking wrong");
    property p_vec;
        $fell(o_bus_wr) |-> o_set_mask && o_sp_wr && o_bus_rd && !o_qfill ##1
        o_bus_rd && o_bus_addr == $past(o_bus_addr) + 16'h0001 ##1 !o_bus_rd
        ##1 (o_bus_rd && o_qfill)[*3] ##1 o_pc_wr;
    endproperty
    a_vec: assert property (p_vec) else $error("vector fetch");
    property p_trap;
        !o_busy && i_boundary && i_trap_op |=> o_bus_wr && o_bus_addr == $past(i_sp);
    endproperty
    a_trap: assert property (p_trap) else $error("trap not entered");
    property p_wait;
        i_wait_op && !o_busy && !i_boundary |=> o_clr_mask && !o_cpu_clk_en;
    endproperty
    a_wait: assert property (p_wait) else $error("wait entry wrong");
    // main scenarios reached
    c_entry: cover property (o_set_mask);
    c_postinc: cover property (o_hx_wr);
    c_wake: cover property ($rose(o_cpu_clk_en));
endmodule
bind caes_seq caes_seq_asserts chk_u (.*);

//--- verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    typedef struct {logic [3:0] m; logic c; int n; logic [15:0] p;} caes_row_t;
    logic        i_sys_clk, i_rstn, i_ext_rst_n, i_src_done, i_boundary;
    logic        i_trap_op, i_wait_op, i_mask_clr, i_ea_req, i_br_cond;
    logic        i_dbg_halt, i_dbg_go;
    logic [15:0] i_pc, i_hx, i_sp, e;
    logic [7:0]  i_acc, i_ccr, i_irq_pend;
    logic [3:0]  i_ea_mode;
    wire  [7:0]  i_bus_rdata, o_bus_wdata, o_opnd;
    wire  [15:0] o_bus_addr, o_ea, o_hx_new, o_sp_new, o_pc_new;
    wire         o_bus_rd, o_bus_wr, o_qfill, o_busy, o_ea_done, o_hx_wr;
    wire         o_sp_wr, o_pc_wr, o_set_mask, o_clr_mask, o_cpu_clk_en, o_bgnd;
    int          errors, compares, cycles, rd_cnt, r0;
    // mode, branch taken, reads, pc
    caes_row_t rows [15] = '{'{4'h0, 1, 0, 16'h2000}, '{4'h1, 1, 1, 16'h2000},
        '{4'h1, 1, 1, 16'h20F0}, '{4'h1, 0, 1, 16'h2000}, '{4'h2, 0, 1, 16'h2010},
        '{4'h3, 0, 2, 16'h2020}, '{4'h4, 0, 2, 16'h2030}, '{4'h5, 0, 3, 16'h2040},
        '{4'h6, 0, 1, 16'h2050}, '{4'h7, 0, 1, 16'h2060}, '{4'h8, 0, 2, 16'h2070},
        '{4'h9, 0, 2, 16'h2080}, '{4'hA, 0, 3, 16'h2090}, '{4'hB, 0, 2, 16'h20A0},
        '{4'hC, 0, 3, 16'h20B0}};
    caes_seq dut_u (.*);
    caes_mem_model mem_u (.i_sys_clk(i_sys_clk), .i_addr(o_bus_addr),
        .i_rd(o_bus_rd), .i_wr(o_bus_wr), .i_wdata(o_bus_wdata),
        .o_rdata(i_bus_rdata));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] pat(input logic [15:0] a);
        pat = a[7:0] ^ a[15:8] ^ 8'hA5;
    endfunction
    // sums wrap at the top of the space
    function automatic logic [15:0] exp_ea(input caes_row_t r);
        logic [15:0] b, w;
        b = {8'h00, pat(r.p)};
        w = {pat(r.p), pat(r.p + 16'h0001)};
        case (r.m)
            4'h0: exp_ea = 16'h0000;
            4'h1: exp_ea = r.p + 16'h0001 + (r.c ? {{8{b[7]}}, b[7:0]} : 16'h0);
            4'h2, 4'h4: exp_ea = b;
            4'h3, 4'h5: exp_ea = w;
            4'h6, 4'h7: exp_ea = i_hx;
            4'h8, 4'h9: exp_ea = i_hx + b;
            4'hA: exp_ea = i_hx + w;
            4'hB: exp_ea = i_sp + b;
            default: exp_ea = i_sp + w;
        endcase
    endfunction
    task check(input logic [15:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task end_of_test;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task wait_idle;
        do @(negedge i_sys_clk); while (o_busy !== 1'b0);
    endtask
    task rst_end;
        int n0;
        n0 = rd_cnt;
        i_src_done <= 1'b1;
        wait_idle;
        check(o_pc_new, {pat(16'hFFFE), pat(16'hFFFF)});
        check(16'(rd_cnt - n0), 16'h0005);
        @(posedge i_sys_clk);
    endtask
    // entry tail: vector target and stack image
    task finish_entry(input logic [15:0] vec);
        int k;
        logic [7:0] st [5];
        wait_idle;
        st = '{i_pc[7:0], i_pc[15:8], i_hx[7:0], i_acc, i_ccr};
        check(o_pc_new, {pat(vec), pat(vec + 16'h0001)});
        check(o_sp_new, i_sp - 16'h0005);
        for (k = 0; k < 5; k++)
            check(mem_u.mem_q[i_sp - 16'(k)], st[k]);
        @(posedge i_sys_clk);
    endtask
    task entry(input logic [7:0] irq, condition_flags, input logic trap, mclr,
               input logic [15:0] vec);
        {i_irq_pend, i_ccr, i_trap_op, i_mask_clr} <= {irq, condition_flags, trap, mclr};
        i_boundary <= 1'b1;
        @(posedge i_sys_clk);
        {i_irq_pend, i_trap_op, i_mask_clr, i_boundary} <= 11'h000;
        if (vec === 16'h0000) begin
            @(negedge i_sys_clk);
            check(o_busy, 16'h0000);
            @(posedge i_sys_clk);
        end else
            finish_entry(vec);
    endtask
    task sleep;
        i_wait_op <= 1'b1;
        @(posedge i_sys_clk);
        i_wait_op <= 1'b0;
        @(negedge i_sys_clk);
        check({o_clr_mask, o_cpu_clk_en}, 16'h0002);
        @(posedge i_sys_clk);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        i_sys_clk = 1'b0;
        forever #4 i_sys_clk = ~i_sys_clk;
    end
    // cycle ceiling well above the whole sequence
    always @(posedge i_sys_clk) begin
        cycles <= cycles + 1;
        if (o_bus_rd === 1'b1)
            rd_cnt <= rd_cnt + 1;
        if (cycles == 3000) begin
            errors++;
            end_of_test;
        end
    end
    initial begin
        {i_rstn, i_ext_rst_n, i_src_done, i_boundary, i_trap_op} = 5'h00;
        {i_wait_op, i_mask_clr, i_ea_req, i_br_cond, i_dbg_halt, i_dbg_go} = 6'h00;
        {i_pc, i_hx, i_sp, i_ea_mode} = {16'h2000, 16'hFFFF, 16'h08F0, 4'h0};
        {i_acc, i_ccr, i_irq_pend} = 24'h5C0000;
        {errors, compares, cycles, rd_cnt} = 128'h0;
        repeat (10) @(posedge i_sys_clk);
        check({o_busy, o_cpu_clk_en}, 16'h0002);
        i_rstn <= 1'b1;
        repeat (8) @(posedge i_sys_clk);
        i_ext_rst_n <= 1'b1;
        repeat (8) @(posedge i_sys_clk);
        check(16'(rd_cnt), 16'h0000);
        rst_end;
        foreach (rows[i]) begin
            r0 = rd_cnt;
            {i_pc, i_ea_mode, i_br_cond} <= {rows[i].p, rows[i].m, rows[i].c};
            i_ea_req <= 1'b1;
            @(posedge i_sys_clk);
            i_ea_req <= 1'b0;
            do @(negedge i_sys_clk); while (o_ea_done !== 1'b1);
            e = exp_ea(rows[i]);
            check(o_ea, e);
            check(16'(rd_cnt - r0), 16'(rows[i].n));
            if (rows[i].m > 4'h3)
                check(o_opnd, pat(e));
            check(o_hx_wr, rows[i].m == 4'h7 || rows[i].m == 4'h9);
            if (o_hx_wr === 1'b1)
                check(o_hx_new, i_hx + 16'h0001);
            @(posedge i_sys_clk);
        end
        {i_pc, i_hx} <= {16'h3456, 16'hABCD};
        @(posedge i_sys_clk);
        entry(8'h01, 8'h08, 1'b0, 1'b0, 16'h0000);
        entry(8'h01, 8'h00, 1'b0, 1'b1, 16'h0000);
        entry(8'h06, 8'h00, 1'b0, 1'b0, 16'hFFF8);
        entry(8'h00, 8'h08, 1'b1, 1'b0, 16'hFFFC);
        i_ccr <= 8'h00;
        sleep;
        i_irq_pend <= 8'h04;
        @(posedge i_sys_clk);
        i_irq_pend <= 8'h00;
        finish_entry(16'hFFF6);
        sleep;
        i_dbg_halt <= 1'b1;
        @(posedge i_sys_clk);
        i_dbg_halt <= 1'b0;
        @(negedge i_sys_clk);
        check({o_cpu_clk_en, o_bgnd}, 16'h0003);
        @(posedge i_sys_clk);
        i_dbg_go <= 1'b1;
        @(posedge i_sys_clk);
        i_dbg_go <= 1'b0;
        @(negedge i_sys_clk);
        check({o_bgnd, o_busy}, 16'h0000);
        @(posedge i_sys_clk);
        {i_trap_op, i_boundary} <= 2'h3;
        @(posedge i_sys_clk);
        {i_trap_op, i_boundary} <= 2'h0;
        repeat (3) @(posedge i_sys_clk);
        i_rstn <= 1'b0;
        #1;
        check({o_bus_wr, o_busy}, 16'h0001);
        @(posedge i_sys_clk);
        i_rstn <= 1'b1;
        rst_end;
        end_of_test;
    end
endmodule
